// *** include/agm_defs.svh ***
// Purpose: addresses, field positions and reset values of the gain/mute/option bank
// Assumes: byte-wide registers at their printed addresses
// Notes:   included by the package and by the design files
`ifndef AGM_DEFS_SVH
`define AGM_DEFS_SVH

// =====================================================================
// addresses
`define AGM_ADDR_LEFT      8'h20
`define AGM_ADDR_RIGHT     8'h21
`define AGM_ADDR_OPT       8'h41
`define AGM_ADDR_SOFTRST   8'hFF
`define AGM_SOFTRST_CODE   8'hFF

// =====================================================================
// gain register fields
`define AGM_CODE_MSB       5
`define AGM_CODE_LSB       0
`define AGM_SILENCE_N_BIT  6
`define AGM_HALT_BIT       7
`define AGM_CODE_MUTE      6'h00
`define AGM_CODE_UNITY     6'h37
`define AGM_CODE_MAX       6'h3F
`define AGM_GAIN_STEP_HDB  9'sh003
`define AGM_GAIN_RST       8'h00

// =====================================================================
// option register fields
`define AGM_OPT_FIXED_BIT  0
`define AGM_OPT_IDLE_BIT   1
`define AGM_OPT_MIDX_BIT   2
`define AGM_OPT_ORDER_BIT  3
`define AGM_OPT_FIXED_VAL  1'h1
`define AGM_OPT_RST        3'h1

`endif

// *** include/agm_pkg.sv ***
// Purpose: types and gain arithmetic shared by the bank and its channel slice
// Assumes: agm_defs.svh on the include path
// Notes:   gain is reported in half-dB units, signed
`include "agm_defs.svh"

package agm_pkg;

  // =====================================================================
  // types
  typedef logic signed [8:0] agm_hdb_t;

  typedef struct packed {
    logic [7:0] left_reg;
    logic [7:0] right_reg;
    logic [3:1] opt_reg;
    logic [7:0] rdata;
    logic [5:0] l_code;
    logic [5:0] r_code;
    logic       l_mute;
    logic       r_mute;
    logic       l_halt;
    logic       r_halt;
    agm_hdb_t   l_hdb;
    agm_hdb_t   r_hdb;
  } agm_state_s;

  // =====================================================================
  // gain in half-dB: unity code is 0 dB, each step 1.5 dB
  function automatic agm_hdb_t agm_gain_hdb(input logic [5:0] code);
    agm_hdb_t d;
    d = $signed({3'h0, code}) - $signed({3'h0, `AGM_CODE_UNITY});
    return d * `AGM_GAIN_STEP_HDB;
  endfunction

endpackage

// *** rtl/agm_chan.sv ***
// Purpose: one channel's choice between register and pin settings
// Assumes: pins synchronous to the clock
// Notes:   purely combinational; the bank registers the results
`include "agm_defs.svh"

module agm_chan (
  input  wire logic             combined,
  input  wire logic [7:0]       gain_reg,
  input  wire logic [5:0]       vol_pins,
  input  wire logic             silence_pin_n,
  output logic      [5:0]       code,
  output logic                  mute,
  output logic                  halt,
  output agm_pkg::agm_hdb_t     hdb
);

  logic reg_gain_ok;
  logic reg_mute_ok;

  always_comb begin
    reg_gain_ok = combined && (vol_pins == 6'h00);
    code        = reg_gain_ok ? gain_reg[`AGM_CODE_MSB:`AGM_CODE_LSB]
                              : vol_pins;
    reg_mute_ok = combined && !silence_pin_n;
    // register bit is active low, as is the pin
    mute        = (reg_mute_ok ? !gain_reg[`AGM_SILENCE_N_BIT] : !silence_pin_n)
                  || (code == `AGM_CODE_MUTE);
    halt        = gain_reg[`AGM_HALT_BIT];
    hdb         = agm_pkg::agm_gain_hdb(code);
  end

endmodule

// *** rtl/agm_regs.sv ***
// Purpose: volume, mute, output-halt and modulator option registers
// Assumes: a serial-bus front end delivers decoded byte reads and writes
// Notes:   every output is a flop; option settings reach the outputs one cycle after a write, gain settings two
//
// Notes on behaviour
// - six-bit volume code per channel, 64 steps
// - codes span +12 to -81 dB, 1.5 dB steps
// - linear; 110111 unity, all-zeros mutes
// - left code at 20h, right at 21h, bits 5:0
// - register codes only in combined mode, pins low
// - bit 6 active-low per-channel mute
// - register mute only when combined and pin low
// - bit 7 stops that channel's PWM output
// - idle-pulse bit: 0 idle, 1 50% pulse
// - modulation index bit: 0 87.5%, 1 100%
// - shaper order bit: 0 seventh, 1 fifth
// - idle-pulse resets to 1, bit 0 fixed at 1, other bits 0
// - writing FFh to FFh restores all registers
`include "agm_defs.svh"

module agm_regs (
  input  wire logic                REF_CLK,
  input  wire logic                RST_N,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  input  wire logic [7:0]          REG_ADDR,
  input  wire logic [7:0]          REG_WDATA,
  output logic      [7:0]          REG_RDATA,
  input  wire logic                COMBINED_MODE,
  input  wire logic                VOLUME_PIN_0,
  input  wire logic                VOLUME_PIN_1,
  input  wire logic                VOLUME_PIN_2,
  input  wire logic                VOLUME_PIN_3,
  input  wire logic                VOLUME_PIN_4,
  input  wire logic                VOLUME_PIN_5,
  input  wire logic                SILENCE_PIN_N,
  output logic      [5:0]          LEFT_VOLUME_CODE,
  output logic      [5:0]          RIGHT_VOLUME_CODE,
  output agm_pkg::agm_hdb_t        LEFT_GAIN_HDB,
  output agm_pkg::agm_hdb_t        RIGHT_GAIN_HDB,
  output logic                     LEFT_MUTED,
  output logic                     RIGHT_MUTED,
  output logic                     LEFT_OUTPUT_HALT,
  output logic                     RIGHT_OUTPUT_HALT,
  output logic                     IDLE_PULSE_SELECT,
  output logic                     MODULATION_INDEX_SELECT,
  output logic                     SHAPER_ORDER_SELECT
);

  // =====================================================================
  // state
  agm_pkg::agm_state_s st;
  agm_pkg::agm_state_s next_st;
  logic [5:0]          vol_pins;
  logic [5:0]          l_code;
  logic [5:0]          r_code;
  logic                l_mute;
  logic                r_mute;
  logic                l_halt;
  logic                r_halt;
  agm_pkg::agm_hdb_t   l_hdb;
  agm_pkg::agm_hdb_t   r_hdb;
  logic                soft_rst;

  assign vol_pins = {VOLUME_PIN_5, VOLUME_PIN_4, VOLUME_PIN_3,
                     VOLUME_PIN_2, VOLUME_PIN_1, VOLUME_PIN_0};

  // =====================================================================
  // channel slices
  agm_chan u_left (
    .combined      (COMBINED_MODE),
    .gain_reg      (st.left_reg),
    .vol_pins      (vol_pins),
    .silence_pin_n (SILENCE_PIN_N),
    .code          (l_code),
    .mute          (l_mute),
    .halt          (l_halt),
    .hdb           (l_hdb)
  );

  agm_chan u_right (
    .combined      (COMBINED_MODE),
    .gain_reg      (st.right_reg),
    .vol_pins      (vol_pins),
    .silence_pin_n (SILENCE_PIN_N),
    .code          (r_code),
    .mute          (r_mute),
    .halt          (r_halt),
    .hdb           (r_hdb)
  );

  // =====================================================================
  // next state
  always_comb begin
    next_st  = st;
    soft_rst = REG_WR && (REG_ADDR == `AGM_ADDR_SOFTRST)
               && (REG_WDATA == `AGM_SOFTRST_CODE);
    if (REG_WR) begin
      case (REG_ADDR)
        `AGM_ADDR_LEFT:  next_st.left_reg = REG_WDATA;
        `AGM_ADDR_RIGHT: next_st.right_reg = REG_WDATA;
        // upper nibble reserved and bit 0 fixed: only bits 3:1 are stored
        `AGM_ADDR_OPT:   next_st.opt_reg = REG_WDATA[3:1];
        default: begin
        end
      endcase
    end
    if (soft_rst) begin
      next_st.left_reg  = `AGM_GAIN_RST;
      next_st.right_reg = `AGM_GAIN_RST;
      next_st.opt_reg   = `AGM_OPT_RST;
    end
    if (REG_RD) begin
      case (REG_ADDR)
        `AGM_ADDR_LEFT:  next_st.rdata = st.left_reg;
        `AGM_ADDR_RIGHT: next_st.rdata = st.right_reg;
        `AGM_ADDR_OPT:   next_st.rdata = {4'h0, st.opt_reg, `AGM_OPT_FIXED_VAL};
        // soft-reset location is write-only; unmapped reads give zero
        default:         next_st.rdata = 8'h00;
      endcase
    end
    next_st.l_code = l_code;
    next_st.r_code = r_code;
    next_st.l_mute = l_mute;
    next_st.r_mute = r_mute;
    next_st.l_halt = l_halt;
    next_st.r_halt = r_halt;
    next_st.l_hdb  = l_hdb;
    next_st.r_hdb  = r_hdb;
  end

  // =====================================================================
  // registers
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      st           <= '0;
      st.opt_reg   <= `AGM_OPT_RST;
      st.left_reg  <= `AGM_GAIN_RST;
      st.right_reg <= `AGM_GAIN_RST;
      st.l_mute    <= 1'h1;
      st.r_mute    <= 1'h1;
      st.l_hdb     <= agm_pkg::agm_gain_hdb(`AGM_CODE_MUTE);
      st.r_hdb     <= agm_pkg::agm_gain_hdb(`AGM_CODE_MUTE);
    end else begin
      st <= next_st;
    end
  end

  // =====================================================================
  // outputs
  assign REG_RDATA               = st.rdata;
  assign LEFT_VOLUME_CODE        = st.l_code;
  assign RIGHT_VOLUME_CODE       = st.r_code;
  assign LEFT_GAIN_HDB           = st.l_hdb;
  assign RIGHT_GAIN_HDB          = st.r_hdb;
  assign LEFT_MUTED              = st.l_mute;
  assign RIGHT_MUTED             = st.r_mute;
  assign LEFT_OUTPUT_HALT        = st.l_halt;
  assign RIGHT_OUTPUT_HALT       = st.r_halt;
  assign IDLE_PULSE_SELECT       = st.opt_reg[`AGM_OPT_IDLE_BIT];
  assign MODULATION_INDEX_SELECT = st.opt_reg[`AGM_OPT_MIDX_BIT];
  assign SHAPER_ORDER_SELECT     = st.opt_reg[`AGM_OPT_ORDER_BIT];

  // =====================================================================
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sequence wr_opt_s;
    REG_WR && REG_ADDR == `AGM_ADDR_OPT && !REG_RD;
  endsequence

  sequence rd_opt_s;
    REG_RD && !REG_WR && REG_ADDR == `AGM_ADDR_OPT;
  endsequence

  // a write right after the restore may legally move the option bits again;
  // mute only follows the cleared codes where the pins hand control to the bus
  soft_reset_a: assert property (REG_WR && REG_ADDR == 8'hFF && REG_WDATA == 8'hFF
    |=> st.left_reg == 8'h00 && st.right_reg == 8'h00 && st.opt_reg == 3'h1
        ##1 ($past(REG_WR) || IDLE_PULSE_SELECT && !MODULATION_INDEX_SELECT
             && !SHAPER_ORDER_SELECT)
            && (!$past(COMBINED_MODE) || $past(vol_pins) != 6'h00
                || LEFT_MUTED && RIGHT_MUTED))
    else $error("soft reset did not restore defaults");

  opt_readback_a: assert property (wr_opt_s ##1 rd_opt_s
    |=> REG_RDATA == (($past(REG_WDATA, 2) & 8'h0E) | 8'h01))
    else $error("option register readback wrong");

  opt_reserved_a: assert property (rd_opt_s |=> REG_RDATA[7:4] == 4'h0 && REG_RDATA[0])
    else $error("reserved or fixed option bits wrong");

  left_write_a: assert property (REG_WR && REG_ADDR == 8'h20 && !(REG_RD)
    |=> st.left_reg == $past(REG_WDATA))
    else $error("left gain write lost");

  reg_gain_path_a: assert property (COMBINED_MODE && vol_pins == 6'h00
    |=> LEFT_VOLUME_CODE == $past(st.left_reg[5:0])
        && RIGHT_VOLUME_CODE == $past(st.right_reg[5:0]))
    else $error("register gain not applied");

  pin_gain_path_a: assert property (!COMBINED_MODE || vol_pins != 6'h00
    |=> LEFT_VOLUME_CODE == $past(vol_pins) && RIGHT_VOLUME_CODE == $past(vol_pins))
    else $error("pin gain not applied");

  zero_code_mute_a: assert property (LEFT_VOLUME_CODE == 6'h00 |-> LEFT_MUTED)
    else $error("zero code not muted");

  unity_gain_a: assert property (LEFT_VOLUME_CODE == 6'h37 |-> LEFT_GAIN_HDB == 9'sh000
    && (RIGHT_VOLUME_CODE != 6'h3F || RIGHT_GAIN_HDB == 9'sh018))
    else $error("gain scale wrong");

  reg_mute_a: assert property (COMBINED_MODE && !SILENCE_PIN_N
    |=> LEFT_MUTED == ($past(!st.left_reg[6]) || LEFT_VOLUME_CODE == 6'h00))
    else $error("register mute bit not applied");

  pin_mute_a: assert property (SILENCE_PIN_N && COMBINED_MODE
    |=> RIGHT_MUTED == (RIGHT_VOLUME_CODE == 6'h00))
    else $error("high mute pin did not release mute");

  halt_follow_a: assert property (##1 LEFT_OUTPUT_HALT == $past(st.left_reg[7])
    && RIGHT_OUTPUT_HALT == $past(st.right_reg[7]))
    else $error("output halt not following register");

  idle_follow_a: assert property (wr_opt_s ##1 !REG_WR[*2]
    |-> IDLE_PULSE_SELECT == $past(REG_WDATA[1], 2)
        && MODULATION_INDEX_SELECT == $past(REG_WDATA[2], 2)
        && SHAPER_ORDER_SELECT == $past(REG_WDATA[3], 2))
    else $error("option outputs not following write");

endmodule

// *** bench/agm_host.sv ***
// Purpose: bus host model that writes and reads the gain/option bank
// Assumes: byte strobes sampled on the rising edge, read data one edge later
// Notes:   released address/data show the inverse of the last value
module agm_host (
  input  wire logic       REF_CLK,
  output logic            REG_WR,
  output logic            REG_RD,
  output logic [7:0]      REG_ADDR,
  output logic [7:0]      REG_WDATA,
  input  wire logic [7:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 100ps;

  // =====================================================================
  // idle bus
  initial begin
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
    REG_ADDR  = 8'h00;
    REG_WDATA = 8'h00;
  end

  // stale address must not pass for a live one
  task automatic release_bus();
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
    REG_ADDR  = ~REG_ADDR;
    REG_WDATA = ~REG_WDATA;
  endtask

  // =====================================================================
  // byte access, one idle cycle between calls
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    #1;
    REG_WR    = 1'b1;
    REG_ADDR  = a;
    REG_WDATA = d;
    @(posedge REF_CLK);
    #1;
    release_bus();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge REF_CLK);
    #1;
    REG_RD   = 1'b1;
    REG_ADDR = a;
    @(posedge REF_CLK);
    #1;
    d = REG_RDATA;
    release_bus();
  endtask

  // whole-bank restore needs both address and code at all ones
  task automatic soft_reset();
    wr(8'hFF, 8'hFF);
  endtask
endmodule

// *** bench/tb_top.sv ***
// Purpose: self-checking bench for the gain/mute/option bank
// Assumes: host model drives the register strobes
// Notes:   derived outputs checked two edges after each change
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // =====================================================================
  // signals
  logic                ref_clk;
  logic                rst_n;
  logic                combined;
  logic [5:0]          vpin;
  logic                silence_n;
  logic                reg_wr;
  logic                reg_rd;
  logic [7:0]          reg_addr;
  logic [7:0]          reg_wdata;
  logic [7:0]          reg_rdata;
  logic [5:0]          l_code;
  logic [5:0]          r_code;
  agm_pkg::agm_hdb_t   l_hdb;
  agm_pkg::agm_hdb_t   r_hdb;
  logic                l_mute;
  logic                r_mute;
  logic                l_halt;
  logic                r_halt;
  logic                idle_sel;
  logic                midx_sel;
  logic                order_sel;
  logic [7:0]          rv;
  logic [7:0]          codes [4];
  logic [7:0]          opts [5];
  int                  bad_count;
  int                  tests_run;

  always #2 ref_clk = ~ref_clk;

  agm_host u_host (
    .REF_CLK   (ref_clk),
    .REG_WR    (reg_wr),
    .REG_RD    (reg_rd),
    .REG_ADDR  (reg_addr),
    .REG_WDATA (reg_wdata),
    .REG_RDATA (reg_rdata)
  );

  agm_regs u_dut (
    .REF_CLK                 (ref_clk),
    .RST_N                   (rst_n),
    .REG_WR                  (reg_wr),
    .REG_RD                  (reg_rd),
    .REG_ADDR                (reg_addr),
    .REG_WDATA               (reg_wdata),
    .REG_RDATA               (reg_rdata),
    .COMBINED_MODE           (combined),
    .VOLUME_PIN_0            (vpin[0]),
    .VOLUME_PIN_1            (vpin[1]),
    .VOLUME_PIN_2            (vpin[2]),
    .VOLUME_PIN_3            (vpin[3]),
    .VOLUME_PIN_4            (vpin[4]),
    .VOLUME_PIN_5            (vpin[5]),
    .SILENCE_PIN_N           (silence_n),
    .LEFT_VOLUME_CODE        (l_code),
    .RIGHT_VOLUME_CODE       (r_code),
    .LEFT_GAIN_HDB           (l_hdb),
    .RIGHT_GAIN_HDB          (r_hdb),
    .LEFT_MUTED              (l_mute),
    .RIGHT_MUTED             (r_mute),
    .LEFT_OUTPUT_HALT        (l_halt),
    .RIGHT_OUTPUT_HALT       (r_halt),
    .IDLE_PULSE_SELECT       (idle_sel),
    .MODULATION_INDEX_SELECT (midx_sel),
    .SHAPER_ORDER_SELECT     (order_sel)
  );

  // =====================================================================
  // helpers
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, rv);
    chk({1'b0, rv}, {1'b0, exp});
  endtask

  // derived outputs lag a gain write by two edges, a pin change by one
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // no handshake here to hang on, but cap the run anyway
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    give_verdict();
  end

  // =====================================================================
  // main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    combined = 1'b1;
    vpin = 6'h00;
    silence_n = 1'b0;
    bad_count = 0;
    tests_run = 0;
    codes = '{8'h3F, 8'h37, 8'h01, 8'h20};
    opts = '{8'hFF, 8'h02, 8'h04, 8'h08, 8'h00};
    repeat (20) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    chk(idle_sel, 1'b1);
    chk({midx_sel, order_sel, l_halt, r_halt}, 4'h0);
    chk({l_mute, r_mute}, 2'h3);
    chk(l_hdb, 9'h15B);
    rchk(8'h20, 8'h00);
    rchk(8'h21, 8'h00);
    rchk(8'h41, 8'h03);
    // gain table corners: max, unity, lowest step, mid
    foreach (codes[i]) begin
      u_host.wr(8'h20, {2'b01, codes[i][5:0]});
      settle();
      chk(l_code, codes[i][5:0]);
      chk(l_hdb, 9'((int'(codes[i]) - 55) * 3));
      chk({l_mute, l_halt}, 2'h0);
      rchk(8'h20, {2'b01, codes[i][5:0]});
    end
    u_host.wr(8'h21, 8'hC0);
    settle();
    chk({r_code, r_mute}, 7'h01);
    chk(r_halt, 1'b1);
    chk(l_code, 6'h20);
    rchk(8'h21, 8'hC0);
    u_host.wr(8'h20, 8'h37);
    settle();
    chk({l_mute, l_hdb}, 10'h200);
    // right at top code and muted while left sits at unity
    u_host.wr(8'h21, 8'h3F);
    settle();
    chk(r_hdb, 9'h018);
    chk(r_mute, 1'b1);
    u_host.wr(8'h20, 8'h41);
    vpin = 6'h05;
    settle();
    chk({l_code, r_code}, 12'h145);
    chk(r_hdb, 9'h16A);
    vpin = 6'h00;
    combined = 1'b0;
    settle();
    chk({l_code, l_mute}, 7'h01);
    combined = 1'b1;
    settle();
    chk({l_code, l_mute}, 7'h02);
    silence_n = 1'b1;
    u_host.wr(8'h20, 8'h01);
    settle();
    chk(l_mute, 1'b0);
    silence_n = 1'b0;
    settle();
    chk(l_mute, 1'b1);
    // both channels muted before any modulator setting changes
    chk({l_mute, r_mute}, 2'h3);
    foreach (opts[i]) begin
      u_host.wr(8'h41, opts[i]);
      settle();
      chk(idle_sel, opts[i][1]);
      chk(midx_sel, opts[i][2]);
      chk(order_sel, opts[i][3]);
      rchk(8'h41, {4'h0, opts[i][3:1], 1'b1});
    end
    u_host.wr(8'hFF, 8'h00);
    u_host.wr(8'h30, 8'hAA);
    rchk(8'h20, 8'h01);
    rchk(8'h30, 8'h00);
    rchk(8'hFF, 8'h00);
    u_host.soft_reset();
    settle();
    rchk(8'h20, 8'h00);
    rchk(8'h21, 8'h00);
    rchk(8'h41, 8'h03);
    chk({idle_sel, r_halt, r_mute}, 3'h5);
    give_verdict();
  end
endmodule
